// [tss_top.sv]
// Our own choice: strobed register access.
module tss_top
   import tss_pkg::*;
#(
   parameter int UV_QUAL_CYCLES = UV_QUAL_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // Register port
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // Comparators
   input  wire logic              temp_warn_cmp,
   input  wire logic              critical_heat_flag_cmp,
   input  wire logic              temp_por_cmp,
   input  wire logic              vsys_below_upper,
   input  wire logic              vsys_below_lower,
   input  wire logic              powered_down_state,
   // OTP defaults
   input  wire logic [UV_W-1:0]   otp_uv_level,
   input  wire logic [HYST_W-1:0] otp_hyst,
   input  wire logic [7:0]        otp_temp_offset,
   // Clocks out
   output logic                   conv_clk,
   output logic                   core_clk_en,
   // Analog trims
   output logic [TRIM_W-1:0]      oscillator_trim_field,
   output logic [UV_W-1:0]        undervoltage_level_field,
   output logic [HYST_W-1:0]      supply_hysteresis_field,
   // System control
   output logic                   irq,
   output logic                   wake_req,
   output logic                   shutdown_reset,
   output logic                   core_por,
   output logic                   system_reset_out_n,
   output logic                   supply_fault_out_n
);
   localparam logic [CNT_W-1:0] UV_LAST =
      CNT_W'(UV_QUAL_CYCLES - 1);

   tss_sup_e         sup;
   tss_sup_e         next_sup;
   logic [CNT_W-1:0] uv_cnt;
   logic [3:0]       conv_cnt;
   logic [3:0]       core_cnt;
   logic             temp_warn_d;
   logic             vwarn_d;
   logic             crit_active;
   logic             next_crit;
   logic             wake_pend;
   logic             otp_loaded;
   logic             fault_out_en;
   logic [7:0]       temp_offset;
   logic [7:0]       mask_a;
   logic [7:0]       mask_b;
   logic [7:0]       mask_c;
   logic [7:0]       mask_d;
   logic [7:0]       event_a;
   logic [7:0]       event_b;
   logic [7:0]       fault_log;
   logic [7:0]       evt_b_set;
   logic [7:0]       evt_b_clr;
   logic [7:0]       fl_set;
   logic [7:0]       fl_clr;
   logic [7:0]       rd_mux;
   logic             ev_temp;
   logic             ev_vwarn;
   logic             uv_expire;
   logic             wr_hit;

   assign wr_hit    = reg_wr;
   assign ev_temp   = temp_warn_cmp & ~temp_warn_d;
   assign ev_vwarn  = vsys_below_upper & ~vwarn_d;
   assign uv_expire = (sup == SUP_QUAL) && vsys_below_lower
                      && (uv_cnt == UV_LAST);

   // Oscillator dividers; clk stands in for the oscillator
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_cnt <= 4'h0;
         conv_clk <= 1'b0;
      end else if (conv_cnt == CONV_HALF - 4'h1) begin
         conv_cnt <= 4'h0;
         conv_clk <= ~conv_clk;
      end else begin
         conv_cnt <= conv_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_cnt    <= 4'h0;
         core_clk_en <= 1'b0;
      end else if (core_cnt == CORE_DIV - 4'h1) begin
         core_cnt    <= 4'h0;
         core_clk_en <= 1'b1;
      end else begin
         core_cnt    <= core_cnt + 4'h1;
         core_clk_en <= 1'b0;
      end
   end

   // Edge history of comparator levels
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         temp_warn_d <= 1'b0;
         vwarn_d     <= 1'b0;
      end else begin
         temp_warn_d <= temp_warn_cmp;
         vwarn_d     <= vsys_below_upper;
      end
   end

   // Core POR while over the top temperature level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         core_por <= 1'b0;
      end else begin
         core_por <= temp_por_cmp;
      end
   end

   // Critical fault latches and holds above warning level
   assign next_crit = critical_heat_flag_cmp | (crit_active & temp_warn_cmp);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         crit_active <= 1'b0;
      end else begin
         crit_active <= next_crit;
      end
   end

   // Wake request pulse, with a level kept until power-up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_req  <= 1'b0;
         wake_pend <= 1'b0;
      end else begin
         wake_req  <= ev_temp & powered_down_state;
         if (ev_temp & powered_down_state) begin
            wake_pend <= 1'b1;
         end else if (!powered_down_state) begin
            wake_pend <= 1'b0;
         end
      end
   end

   // Supply supervision
   always_comb begin
      next_sup = sup;
      unique case (sup)
         SUP_GOOD: begin
            if (vsys_below_lower) begin
               next_sup = SUP_QUAL;
            end else if (vsys_below_upper) begin
               next_sup = SUP_WARN;
            end
         end
         SUP_WARN: begin
            if (vsys_below_lower) begin
               next_sup = SUP_QUAL;
            end else if (!vsys_below_upper) begin
               next_sup = SUP_GOOD;
            end
         end
         SUP_QUAL: begin
            if (!vsys_below_lower) begin
               next_sup = SUP_WARN;
            end else if (uv_expire) begin
               next_sup = SUP_SHUT;
            end
         end
         SUP_SHUT: begin
            if (!vsys_below_lower) begin
               next_sup = SUP_WARN;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sup <= SUP_GOOD;
      end else begin
         sup <= next_sup;
      end
   end

   // Counter restarts whenever the rail recovers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         uv_cnt <= '0;
      end else if (sup == SUP_QUAL && vsys_below_lower) begin
         uv_cnt <= uv_cnt + 1'b1;
      end else begin
         uv_cnt <= '0;
      end
   end

   // Shutdown and reset pins follow the next state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shutdown_reset     <= 1'b0;
         system_reset_out_n <= 1'b1;
         supply_fault_out_n <= 1'b1;
      end else begin
         shutdown_reset     <= next_crit | (next_sup == SUP_SHUT);
         system_reset_out_n <= ~(next_crit | temp_por_cmp
                                 | (next_sup == SUP_SHUT));
         supply_fault_out_n <= ~(fault_out_en
                                 & (next_sup == SUP_SHUT));
      end
   end

   // Event and fault latches
   always_comb begin
      evt_b_set           = 8'h00;
      evt_b_set[EB_TEMP]  = ev_temp;
      evt_b_set[EB_VWARN] = ev_vwarn;
      evt_b_clr = (wr_hit && reg_addr == ADR_EVT_B) ? reg_wdata : 8'h00;
      fl_set            = 8'h00;
      fl_set[FL_CRIT]   = next_crit & ~crit_active;
      fl_set[FL_VFAULT] = uv_expire;
      fl_clr = (wr_hit && reg_addr == ADR_FAULT_LOG) ? reg_wdata : 8'h00;
   end

   tss_sticky #(
      .W(8)
   ) u_event_b (
      .clk      (clk),
      .arst_n   (arst_n),
      .soft_clr (core_por),
      .set      (evt_b_set),
      .clr      (evt_b_clr),
      .q        (event_b)
   );

   // Not cleared by core POR so the cause is seen after restart
   tss_sticky #(
      .W(8)
   ) u_fault_log (
      .clk      (clk),
      .arst_n   (arst_n),
      .soft_clr (1'b0),
      .set      (fl_set),
      .clr      (fl_clr),
      .q        (fault_log)
   );

   // Groups C and D have no sources in this block
   always_comb begin
      event_a           = 8'h00;
      event_a[EA_SUM_B] = |event_b;
      event_a[EA_SUM_C] = 1'b0;
      event_a[EA_SUM_D] = 1'b0;
   end

   // Mask registers; mask B matches event B, mask A keeps only bits 4:0
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_a <= MASK_RST;
         mask_b <= MASK_RST;
         mask_c <= MASK_RST;
         mask_d <= MASK_RST;
      end else if (core_por) begin
         mask_a <= MASK_RST;
         mask_b <= MASK_RST;
         mask_c <= MASK_RST;
         mask_d <= MASK_RST;
      end else if (wr_hit) begin
         if (reg_addr == ADR_MSK_A) begin
            mask_a <= reg_wdata & MSK_A_VALID;
         end
         if (reg_addr == ADR_MSK_B) begin
            mask_b <= reg_wdata;
         end
         if (reg_addr == ADR_MSK_C) begin
            mask_c <= reg_wdata;
         end
         if (reg_addr == ADR_MSK_D) begin
            mask_d <= reg_wdata;
         end
      end
   end

   // Interrupt from unmasked latched events
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_b & ~mask_b);
      end
   end

   // Configuration; OTP defaults load after reset or core POR
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         otp_loaded               <= 1'b0;
         undervoltage_level_field <= '0;
         supply_hysteresis_field  <= '0;
         temp_offset              <= 8'h00;
         oscillator_trim_field    <= TRIM_RST;
         fault_out_en             <= FOUT_EN_RST;
      end else if (core_por) begin
         otp_loaded               <= 1'b0;
         oscillator_trim_field    <= TRIM_RST;
         fault_out_en             <= FOUT_EN_RST;
      end else if (!otp_loaded) begin
         otp_loaded               <= 1'b1;
         undervoltage_level_field <= otp_uv_level;
         supply_hysteresis_field  <= otp_hyst;
         temp_offset              <= otp_temp_offset;
      end else if (wr_hit) begin
         unique case (reg_addr)
            ADR_OSC_TRIM: begin
               oscillator_trim_field <= reg_wdata[TRIM_W-1:0];
            end
            ADR_UV_LEVEL: begin
               undervoltage_level_field <= reg_wdata[UV_W-1:0];
            end
            ADR_HYST: begin
               supply_hysteresis_field <= reg_wdata[HYST_W-1:0];
            end
            ADR_FOUT_EN: begin
               fault_out_en <= reg_wdata[0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read path; data only in the cycle after the strobe
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         ADR_STATUS_A:  rd_mux[SA_WAKE] = wake_pend;
         ADR_FAULT_LOG: rd_mux = fault_log;
         ADR_EVT_A:     rd_mux = event_a;
         ADR_EVT_B:     rd_mux = event_b;
         ADR_MSK_A:     rd_mux = mask_a;
         ADR_MSK_B:     rd_mux = mask_b;
         ADR_MSK_C:     rd_mux = mask_c;
         ADR_MSK_D:     rd_mux = mask_d;
         ADR_OSC_TRIM:  rd_mux = 8'(oscillator_trim_field);
         ADR_UV_LEVEL:  rd_mux = 8'(undervoltage_level_field);
         ADR_HYST:      rd_mux = 8'(supply_hysteresis_field);
         ADR_TEMP_OFS:  rd_mux = temp_offset;
         ADR_SUPV:      rd_mux = {4'h0, sup, crit_active, temp_warn_cmp};
         ADR_FOUT_EN:   rd_mux = {7'h00, fault_out_en};
         default:       rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   property p_temp_evt;
      $rose(temp_warn_cmp) && !core_por |=> event_b[EB_TEMP];
   endproperty
   a_temp_evt: assert property (p_temp_evt)
      else $error("temperature event not set");

   property p_wake;
      ev_temp && powered_down_state |=> wake_req ##1 !wake_req;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake pulse wrong");

   property p_crit;
      critical_heat_flag_cmp |=> fault_log[FL_CRIT] && shutdown_reset
                        && !system_reset_out_n;
   endproperty
   a_crit: assert property (p_crit)
      else $error("critical heat not handled");

   property p_crit_hold;
      crit_active && temp_warn_cmp |=> crit_active;
   endproperty
   a_crit_hold: assert property (p_crit_hold)
      else $error("critical fault dropped early");

   property p_por;
      temp_por_cmp |=> core_por && !system_reset_out_n;
   endproperty
   a_por: assert property (p_por)
      else $error("core POR missing");

   property p_vwarn;
      $rose(vsys_below_upper) && !core_por |=> event_b[EB_VWARN];
   endproperty
   a_vwarn: assert property (p_vwarn)
      else $error("supply warning not set");

   property p_irq_mask;
      event_b[EB_VWARN] && !mask_b[EB_VWARN] |=> irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("unmasked event gave no interrupt");

   property p_uv_fault;
      uv_expire |=> fault_log[FL_VFAULT] && sup == SUP_SHUT;
   endproperty
   a_uv_fault: assert property (p_uv_fault)
      else $error("supply fault not logged");

   property p_rst_out;
      sup == SUP_SHUT |-> !system_reset_out_n && shutdown_reset;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("reset out not asserted");

   property p_fault_pin;
      sup == SUP_SHUT && $past(fault_out_en) |-> !supply_fault_out_n;
   endproperty
   a_fault_pin: assert property (p_fault_pin)
      else $error("fault pin not asserted");

   property p_uv_restart;
      !vsys_below_lower |=> uv_cnt == '0;
   endproperty
   a_uv_restart: assert property (p_uv_restart)
      else $error("qualification not restarted");

   property p_summary;
      reg_rd && reg_addr == ADR_EVT_A |=>
         reg_rdata[EA_SUM_B] == |$past(event_b);
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary bit wrong");

   c_crit: cover property ($rose(crit_active));
   c_uv_shut: cover property (sup == SUP_QUAL ##1 sup == SUP_SHUT);
   c_uv_recover: cover property (sup == SUP_QUAL ##1 sup == SUP_WARN);
   c_irq: cover property ($rose(irq));
endmodule

// [tss_pkg.sv]
// What this block does
// - Divide oscillator to converter and core clocks
// - Software trim shifts oscillator up to ten percent
// - Temperature warning sets event and interrupt
// - Warning while powered down requests wake-up
// - Provide 8-bit temperature offset trim value
// - Critical heat sets flag, shuts to reset
// - Critical fault holds while above warning level
// - Critical flag survives core POR, clears on write-one or reset
// - Over POR level resets digital core immediately
// - Under-voltage level field, default from OTP
// - Hysteresis field sets supply-good level, OTP default
// - Falling below supply-good sets warning event
// - Supply warning interrupts only when unmasked
// - Under-voltage over 100 ms logs fault, shuts down
// - System reset output asserts at shutdown start
// - Optional active-low supply fault output
package tss_pkg;
   // Register offsets
   localparam logic [7:0] ADR_STATUS_A  = 8'h01;
   localparam logic [7:0] ADR_FAULT_LOG = 8'h05;
   localparam logic [7:0] ADR_EVT_A     = 8'h06;
   localparam logic [7:0] ADR_EVT_B     = 8'h07;
   localparam logic [7:0] ADR_EVT_C     = 8'h08;
   localparam logic [7:0] ADR_EVT_D     = 8'h09;
   localparam logic [7:0] ADR_MSK_A     = 8'h0a;
   localparam logic [7:0] ADR_MSK_B     = 8'h0b;
   localparam logic [7:0] ADR_MSK_C     = 8'h0c;
   localparam logic [7:0] ADR_MSK_D     = 8'h0d;
   localparam logic [7:0] ADR_OSC_TRIM  = 8'h40;
   localparam logic [7:0] ADR_UV_LEVEL  = 8'h41;
   localparam logic [7:0] ADR_HYST      = 8'h42;
   localparam logic [7:0] ADR_TEMP_OFS  = 8'h43;
   localparam logic [7:0] ADR_SUPV      = 8'h44;
   localparam logic [7:0] ADR_FOUT_EN   = 8'h45;
   // Field positions
   localparam int SA_WAKE   = 1;
   localparam int FL_CRIT   = 4;
   localparam int FL_VFAULT = 2;
   localparam int EA_SUM_B  = 5;
   localparam int EA_SUM_C  = 6;
   localparam int EA_SUM_D  = 7;
   localparam int EB_VWARN  = 7;
   localparam int EB_TEMP   = 1;
   // Field widths and reset values
   localparam int TRIM_W = 5;
   localparam int UV_W   = 4;
   localparam int HYST_W = 3;
   localparam logic [7:0] MSK_A_VALID = 8'h1f;
   localparam logic [7:0] MASK_RST    = 8'h00;
   localparam logic [TRIM_W-1:0] TRIM_RST = 5'h00;
   localparam logic FOUT_EN_RST = 1'b1;
   // Timing
   localparam int CLK_HZ      = 25_000_000;
   localparam int UV_QUAL_MS  = 100;
   localparam int UV_QUAL_CYC = CLK_HZ / 1000 * UV_QUAL_MS;
   localparam int CNT_W       = 22;
   localparam int OSC_NOM_KHZ = 6000;
   localparam int CONV_KHZ    = 3000;
   localparam int CORE_KHZ    = 1000;
   localparam logic [3:0] CONV_HALF =
      4'(OSC_NOM_KHZ / CONV_KHZ / 2);
   localparam logic [3:0] CORE_DIV = 4'(OSC_NOM_KHZ / CORE_KHZ);
   // Supply supervision states
   typedef enum logic [1:0] {
      SUP_GOOD = 2'b00,
      SUP_WARN = 2'b01,
      SUP_QUAL = 2'b10,
      SUP_SHUT = 2'b11
   } tss_sup_e;
endpackage

// [tss_sticky.sv]
module tss_sticky
   import tss_pkg::*;
#(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // Set and clear
   input  wire logic         soft_clr,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   // Latched value
   output logic      [W-1:0] q
);
   // Set wins over write-one clear and over soft clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else if (soft_clr) begin
         q <= set;
      end else begin
         q <= (q & ~clr) | set;
      end
   end

   property p_set_wins;
      @(posedge clk) disable iff (!arst_n)
      (set != '0) |=> ((q & $past(set)) == $past(set));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event set lost");
endmodule

// [tss_host.sv]
module tss_host (
   // Clock and interrupt
   input  wire logic       clk,
   input  wire logic       irq,
   // Register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   // Host activity
   output logic            load_shed
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // Sheds optional work while the device reports an event
   always @(posedge clk) begin
      load_shed <= irq;
   end

   // Address and data inverted once idle so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

// [tss_top_tb.sv]
module tss_top_tb;
   import tss_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int N = 8;
   typedef struct {
      logic       w;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } tss_row_s;

   logic              clk;
   logic              arst_n;
   logic [7:0]        addr;
   logic [7:0]        wdata;
   logic              wr;
   logic              rd;
   logic [7:0]        rdata;
   logic              tw;
   logic              tc;
   logic              tp;
   logic              vbu;
   logic              vbl;
   logic              pd;
   logic              conv_clk;
   logic              core_en;
   logic [TRIM_W-1:0] trim;
   logic [UV_W-1:0]   uvf;
   logic [HYST_W-1:0] hyf;
   logic              irq;
   logic              wake;
   logic              shut;
   logic              por;
   logic              sro_n;
   logic              sfo_n;
   logic              shed;
   logic [7:0]        d;
   logic              p;
   logic [7:0]        cnt;
   int                mismatches;
   int                samples_checked;
   int                cyc;
   tss_row_s          rows [18];

   tss_top #(.UV_QUAL_CYCLES(N)) dut_u (
      .clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .temp_warn_cmp(tw),
      .critical_heat_flag_cmp(tc), .temp_por_cmp(tp), .vsys_below_upper(vbu),
      .vsys_below_lower(vbl), .powered_down_state(pd),
      .otp_uv_level(4'h9), .otp_hyst(3'h5), .otp_temp_offset(8'ha7),
      .conv_clk(conv_clk), .core_clk_en(core_en),
      .oscillator_trim_field(trim), .undervoltage_level_field(uvf),
      .supply_hysteresis_field(hyf), .irq(irq), .wake_req(wake),
      .shutdown_reset(shut), .core_por(por), .system_reset_out_n(sro_n),
      .supply_fault_out_n(sfo_n));

   tss_host host_u (
      .clk(clk), .irq(irq), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .load_shed(shed));

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t data %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t pin %b expected %b", $time, g, e);
      end
   endtask

   task automatic at(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic results();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Generous ceiling, the sequence needs about 170 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      arst_n = 1'b0;
      {tw, tc, tp, vbu, vbl, pd} = 6'h00;
      rows = '{
         '{1'b0, 8'h0a, 8'h00, 8'h00},
         '{1'b0, 8'h0b, 8'h00, 8'h00},
         '{1'b0, 8'h05, 8'h00, 8'h00},
         '{1'b0, 8'h07, 8'h00, 8'h00},
         '{1'b0, 8'h40, 8'h00, 8'h00},
         '{1'b0, 8'h45, 8'h00, 8'h01},
         '{1'b0, 8'h41, 8'h00, 8'h09},
         '{1'b0, 8'h42, 8'h00, 8'h05},
         '{1'b0, 8'h43, 8'h00, 8'ha7},
         '{1'b1, 8'h40, 8'h1f, 8'h1f},
         '{1'b1, 8'h41, 8'h03, 8'h03},
         '{1'b1, 8'h42, 8'h07, 8'h07},
         '{1'b1, 8'h0a, 8'hff, 8'h1f},
         '{1'b1, 8'h0d, 8'ha5, 8'ha5},
         '{1'b1, 8'h45, 8'h00, 8'h00},
         '{1'b1, 8'h43, 8'h00, 8'ha7},
         '{1'b1, 8'h08, 8'hff, 8'h00},
         '{1'b1, 8'h30, 8'hff, 8'h00}};
      at(5);
      chk1(sro_n, 1'b1);
      chk1(sfo_n, 1'b1);
      chk1(irq, 1'b0);
      @(posedge clk);
      arst_n <= 1'b1;
      at(2);
      for (int i = 0; i < 4; i++) begin
         p = conv_clk;
         at(1);
         chk1(conv_clk, ~p);
      end
      cnt = 8'h00;
      for (int i = 0; i < 12; i++) begin
         at(1);
         cnt = cnt + {7'h00, core_en};
      end
      chk8(cnt, 8'h02);
      foreach (rows[i]) begin
         if (rows[i].w) begin
            host_u.wr(rows[i].a, rows[i].d);
         end
         host_u.rd(rows[i].a, d);
         chk8(d, rows[i].e);
      end
      chk8({3'h0, trim}, 8'h1f);
      chk8({4'h0, uvf}, 8'h03);
      chk8({5'h0, hyf}, 8'h07);
      // Warning while powered down
      @(posedge clk);
      pd <= 1'b1;
      tw <= 1'b1;
      at(1);
      chk1(wake, 1'b1);
      at(1);
      chk1(wake, 1'b0);
      chk1(irq, 1'b1);
      host_u.rd(8'h01, d);
      chk8(d & 8'h02, 8'h02);
      host_u.rd(8'h07, d);
      chk8(d, 8'h02);
      host_u.wr(8'h07, 8'h02);
      at(2);
      chk1(irq, 1'b0);
      // Critical heat, held by the warning comparator
      @(posedge clk);
      pd <= 1'b0;
      tc <= 1'b1;
      at(1);
      chk1(shut, 1'b1);
      chk1(sro_n, 1'b0);
      @(posedge clk);
      tc <= 1'b0;
      at(3);
      chk1(shut, 1'b1);
      @(posedge clk);
      tw <= 1'b0;
      at(3);
      chk1(shut, 1'b0);
      host_u.rd(8'h05, d);
      chk8(d, 8'h10);
      // Core reset keeps the fault log, restores the rest to defaults
      host_u.wr(8'h0b, 8'h80);
      @(posedge clk);
      tp <= 1'b1;
      at(1);
      chk1(por, 1'b1);
      chk1(sro_n, 1'b0);
      @(posedge clk);
      tp <= 1'b0;
      at(4);
      host_u.rd(8'h05, d);
      chk8(d, 8'h10);
      host_u.rd(8'h0b, d);
      chk8(d, 8'h00);
      host_u.rd(8'h40, d);
      chk8(d, 8'h00);
      host_u.rd(8'h41, d);
      chk8(d, 8'h09);
      host_u.rd(8'h45, d);
      chk8(d, 8'h01);
      host_u.wr(8'h05, 8'hff);
      host_u.rd(8'h05, d);
      chk8(d, 8'h00);
      // Supply warning against its mask
      host_u.wr(8'h0b, 8'h80);
      @(posedge clk);
      vbu <= 1'b1;
      at(3);
      chk1(irq, 1'b0);
      host_u.rd(8'h07, d);
      chk8(d, 8'h80);
      host_u.rd(8'h06, d);
      chk8(d & 8'he0, 8'h20);
      host_u.wr(8'h0b, 8'h00);
      at(2);
      chk1(irq, 1'b1);
      chk1(shed, 1'b1);
      @(posedge clk);
      vbu <= 1'b0;
      host_u.wr(8'h07, 8'h80);
      at(2);
      chk1(irq, 1'b0);
      chk1(shed, 1'b0);
      // Under-voltage dip two cycles short, then a full interval
      @(posedge clk);
      vbu <= 1'b1;
      vbl <= 1'b1;
      repeat (N - 1) @(posedge clk);
      vbl <= 1'b0;
      @(posedge clk);
      vbl <= 1'b1;
      at(N);
      chk1(shut, 1'b0);
      at(1);
      chk1(shut, 1'b1);
      chk1(sro_n, 1'b0);
      chk1(sfo_n, 1'b0);
      host_u.rd(8'h05, d);
      chk8(d, 8'h04);
      host_u.rd(8'h44, d);
      chk8(d, 8'h0c);
      @(posedge clk);
      vbl <= 1'b0;
      vbu <= 1'b0;
      at(2);
      chk1(sfo_n, 1'b1);
      results();
   end
endmodule
